// ### rtl/bamo_mapper.v
/*
  Beam-to-analog output mapper: maps a selected beam evaluation result onto a
  12-bit converter code, configured over AXI4-Lite or a local panel port.
  Assumes an external non-volatile word store with a req/ack handshake, and an
  upstream evaluator giving beam states and six results with a cycle strobe.
*/
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "bamo_map.vh"

// What this block does
// [R01] Settings are written back to non-volatile store and restored after reset.
// [R02] The latest write wins, whether from the bus or the panel.
// [R03] Output type field disables the output or selects a voltage/current range.
// [R04] Function field selects none or one of six beam results.
// [R05] Start beam anchors the low end, end beam the high end.
// [R06] End beam below start beam inverts the characteristic.
// [R07] Code steps by full range divided by beam count in the range.
// [R08] Non-inverted: all beams free gives the minimum code.
// [R09] Non-inverted: end beam interrupted gives maximum; inversion swaps ends.
// [R10] Up to three connector pins can be enabled as analog outputs.
// [R11] Evaluation waits until beam states stayed equal for filter depth cycles.
// [R12] Blocked counts under the smoothing figure report no object.
// [R13] The controller should accept a value only once it stopped changing.
// [R14] Filter depth outside 1 to 255 is refused and the old value kept.
// [R15] Code is recomputed at most once per measurement cycle and held in between.
module bamo_mapper #(
  parameter BEAM_W = 8,
  parameter NBEAMS = 32
) (
  input  wire               clk,               // 20 MHz clock
  input  wire               rst_b,             // Async reset, active low
  input  wire [`BAMO_AW-1:0] s_axi_awaddr,     // Write address
  input  wire               s_axi_awvalid,     // Write address valid
  output reg                s_axi_awready,     // Write address ready
  input  wire [31:0]        s_axi_wdata,       // Write data
  input  wire [3:0]         s_axi_wstrb,       // Write byte enables
  input  wire               s_axi_wvalid,      // Write data valid
  output reg                s_axi_wready,      // Write data ready
  output reg  [1:0]         s_axi_bresp,       // Write response
  output reg                s_axi_bvalid,      // Write response valid
  input  wire               s_axi_bready,      // Write response ready
  input  wire [`BAMO_AW-1:0] s_axi_araddr,     // Read address
  input  wire               s_axi_arvalid,     // Read address valid
  output reg                s_axi_arready,     // Read address ready
  output reg  [31:0]        s_axi_rdata,       // Read data
  output reg  [1:0]         s_axi_rresp,       // Read response
  output reg                s_axi_rvalid,      // Read data valid
  input  wire               s_axi_rready,      // Read data ready
  input  wire               panelWrEn,         // Panel write pulse
  input  wire [1:0]         panelIdx,          // Panel register index
  input  wire [31:0]        panelData,         // Panel write word
  output reg                nvReq,             // Store request, held until ack
  output reg                nvWe,              // Store request is a write
  output reg  [1:0]         nvAddr,            // Store word index
  output reg  [31:0]        nvWdata,           // Store write word
  input  wire               nvAck,             // Store acknowledge pulse
  input  wire [31:0]        nvRdata,           // Store read word, valid with ack
  input  wire               measStrobe,        // One pulse per measurement cycle
  input  wire [NBEAMS-1:0]  beamState,         // Beam states, 1 = interrupted
  input  wire [BEAM_W-1:0]  firstBlockedBeam,  // Evaluation results, 0 = none
  input  wire [BEAM_W-1:0]  firstClearBeam,
  input  wire [BEAM_W-1:0]  lastBlockedBeam,
  input  wire [BEAM_W-1:0]  lastClearBeam,
  input  wire [BEAM_W-1:0]  totalBlockedBeams,
  input  wire [BEAM_W-1:0]  totalClearBeams,
  output reg  [11:0]        dacCode,           // Converter code
  output reg  [2:0]         dacType,           // Selected output range
  output reg  [2:0]         dacPinEn,          // Connector pins driven
  output reg                dacUpdate,         // Pulse when dacCode reloads
  output reg                cfgReady           // Settings restored
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV  = 1'b1;

  reg [31:0]        cfg_q [0:`BAMO_NCFG-1];
  reg [31:0]        cfg_d [0:`BAMO_NCFG-1];
  reg [`BAMO_NCFG-1:0] dirty_q, dirtySet, dirtyClr;
  reg [1:0]         loadIdx_q;
  reg [`BAMO_AW-1:0] awAddr_q;
  reg [31:0]        wData_q;
  reg [3:0]         wStrb_q;
  reg               awHave_q, wHave_q, reject_q, rejectSet, rejectClr;
  reg               axiWe, axiMapped, axiOk, panelOk;
  reg [1:0]         axiIdx;
  reg [31:0]        strbMask, axiVal, panelVal;
  reg [NBEAMS-1:0]  prevState_q;
  reg [7:0]         stableCnt_q, cntNext;
  reg               state_q, inv_q, off_q;
  reg [BEAM_W-1:0]  selV_q, lo_q, hi_q, selV, vClamp;
  reg [8:0]         span, offset;
  reg [21:0]        prod;
  reg [11:0]        codeNext;
  reg [2:0]         type_q, pins_q;
  reg               divStart_q;
  wire              divBusy, divDone;
  wire [12:0]       step;
  integer           i;
  integer           j;

  function [31:0] wmask;
    input [1:0] idx;
    begin
      case (idx)
        `BAMO_IDX_CTRL:  wmask = `BAMO_WM_CTRL;
        `BAMO_IDX_RANGE: wmask = `BAMO_WM_RANGE;
        `BAMO_IDX_FILT:  wmask = `BAMO_WM_FILT;
        default:         wmask = 32'h0000_0000;
      endcase
    end
  endfunction

  // Depth outside 1..255 is refused as a whole word
  function depthOk;
    input [1:0]  idx;
    input [31:0] val;
    begin
      depthOk = (idx != `BAMO_IDX_FILT) ||
                ((val[`BAMO_F_DEPTH] >= `BAMO_DEPTH_MIN) &&
                 (val[`BAMO_F_DEPTH] <= `BAMO_DEPTH_MAX)); // R14
    end
  endfunction

  always @* begin
    axiWe     = awHave_q && wHave_q && !s_axi_bvalid;
    axiMapped = (awAddr_q == `BAMO_OFF_CTRL) || (awAddr_q == `BAMO_OFF_RANGE) ||
                (awAddr_q == `BAMO_OFF_FILT);
    axiIdx    = awAddr_q[3:2];
    strbMask  = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    axiVal    = axiMapped ? (((cfg_q[axiIdx] & ~strbMask) | (wData_q & strbMask)) &
                             wmask(axiIdx)) : 32'h0000_0000;
    axiOk     = axiWe && axiMapped && depthOk(axiIdx, axiVal);
    panelVal  = panelData & wmask(panelIdx);
    panelOk   = panelWrEn && cfgReady && (panelIdx <= `BAMO_IDX_LAST) &&
                depthOk(panelIdx, panelVal);
    rejectSet = (axiWe && axiMapped && !axiOk) ||
                (panelWrEn && cfgReady && (panelIdx <= `BAMO_IDX_LAST) && !panelOk);
    rejectClr = (axiOk && (axiIdx == `BAMO_IDX_FILT)) ||
                (panelOk && (panelIdx == `BAMO_IDX_FILT));
    dirtyClr  = {`BAMO_NCFG{1'b0}};
    if (cfgReady && nvReq && nvAck)
      dirtyClr[nvAddr] = 1'b1;
    for (i = 0; i < `BAMO_NCFG; i = i + 1) begin
      cfg_d[i]    = cfg_q[i];
      dirtySet[i] = 1'b0;
      if (axiOk && (axiIdx == i)) begin
        cfg_d[i]    = axiVal;
        dirtySet[i] = 1'b1;
      end
      // Panel applied after the bus: same-cycle collisions go to the panel
      if (panelOk && (panelIdx == i)) begin
        cfg_d[i]    = panelVal; // R02
        dirtySet[i] = 1'b1;
      end
    end
  end

  // Settings, restore and write-back
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q[`BAMO_IDX_CTRL]  <= `BAMO_RST_CTRL;
      cfg_q[`BAMO_IDX_RANGE] <= `BAMO_RST_RANGE;
      cfg_q[`BAMO_IDX_FILT]  <= `BAMO_RST_FILT;
      dirty_q   <= {`BAMO_NCFG{1'b0}};
      loadIdx_q <= 2'h0;
      cfgReady  <= 1'b0;
      reject_q  <= 1'b0;
      nvReq     <= 1'b1;
      nvWe      <= 1'b0;
      nvAddr    <= 2'h0;
      nvWdata   <= 32'h0000_0000;
    end else if (!cfgReady) begin
      if (nvAck) begin
        cfg_q[loadIdx_q] <= nvRdata & wmask(loadIdx_q); // R01
        nvAddr    <= loadIdx_q + 2'h1;
        loadIdx_q <= loadIdx_q + 2'h1;
        if (loadIdx_q == `BAMO_IDX_LAST) begin
          cfgReady <= 1'b1;
          nvReq    <= 1'b0;
        end
      end
    end else begin
      for (j = 0; j < `BAMO_NCFG; j = j + 1)
        cfg_q[j] <= cfg_d[j];
      if (nvReq && nvAck) begin
        nvReq <= 1'b0;
      end else if (!nvReq && (dirty_q != {`BAMO_NCFG{1'b0}})) begin
        nvReq <= 1'b1;
        nvWe  <= 1'b1;
        for (j = `BAMO_NCFG - 1; j >= 0; j = j - 1)
          if (dirty_q[j]) begin
            nvAddr  <= j[1:0];
            nvWdata <= cfg_q[j]; // R01
          end
      end
      // A rewrite landing with the ack stays dirty and is saved again
      dirty_q  <= (dirty_q & ~dirtyClr) | dirtySet; // R01
      reject_q <= rejectSet | (reject_q & ~rejectClr); // R14
    end
  end

  // AXI4-Lite slave, one write and one read at a time
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= {`BAMO_AW{1'b0}};
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BAMO_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BAMO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q      <= 1'b1;
        awAddr_q      <= {s_axi_awaddr[`BAMO_AW-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end else if (!awHave_q && !s_axi_bvalid) begin
        s_axi_awready <= cfgReady;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!wHave_q && !s_axi_bvalid) begin
        s_axi_wready <= cfgReady;
      end
      if (axiWe) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status word is read-only; writes to it are dropped quietly
        s_axi_bresp  <= (axiOk || (awAddr_q == `BAMO_OFF_STAT)) ?
                        `BAMO_RESP_OKAY : `BAMO_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `BAMO_RESP_OKAY;
        case ({s_axi_araddr[`BAMO_AW-1:2], 2'b00})
          `BAMO_OFF_CTRL:  s_axi_rdata <= cfg_q[`BAMO_IDX_CTRL];
          `BAMO_OFF_RANGE: s_axi_rdata <= cfg_q[`BAMO_IDX_RANGE];
          `BAMO_OFF_FILT:  s_axi_rdata <= cfg_q[`BAMO_IDX_FILT];
          `BAMO_OFF_STAT: begin
            s_axi_rdata                 <= {20'h00000, dacCode};
            s_axi_rdata[`BAMO_ST_INV]    <= inv_q;
            s_axi_rdata[`BAMO_ST_LOADED] <= cfgReady;
            s_axi_rdata[`BAMO_ST_REJECT] <= reject_q;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BAMO_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= cfgReady;
      end
    end
  end

  // Result selection, smoothing and stability count
  always @* begin
    cntNext = (beamState == prevState_q) ?
              ((stableCnt_q == 8'hff) ? stableCnt_q : stableCnt_q + 8'h01) : 8'h01;
    case (cfg_q[`BAMO_IDX_CTRL][`BAMO_F_FUNC]) // R04
      `BAMO_FN_FST_BLK: selV = firstBlockedBeam;
      `BAMO_FN_FST_CLR: selV = firstClearBeam;
      `BAMO_FN_LST_BLK: selV = lastBlockedBeam;
      `BAMO_FN_LST_CLR: selV = lastClearBeam;
      `BAMO_FN_TOT_BLK: selV = totalBlockedBeams;
      `BAMO_FN_TOT_CLR: selV = totalClearBeams;
      default:          selV = {BEAM_W{1'b0}};
    endcase
    // Too few blocked beams is not yet an object
    if ((totalBlockedBeams < cfg_q[`BAMO_IDX_FILT][`BAMO_F_SMOOTH]) &&
        ((cfg_q[`BAMO_IDX_CTRL][`BAMO_F_FUNC] == `BAMO_FN_FST_BLK) ||
         (cfg_q[`BAMO_IDX_CTRL][`BAMO_F_FUNC] == `BAMO_FN_LST_BLK) ||
         (cfg_q[`BAMO_IDX_CTRL][`BAMO_F_FUNC] == `BAMO_FN_TOT_BLK)))
      selV = {BEAM_W{1'b0}}; // R12
  end

  // Characteristic from the snapshot taken at the strobe
  always @* begin
    span   = {1'b0, hi_q - lo_q} + 9'h001; // R07
    vClamp = (selV_q < lo_q) ? lo_q : ((selV_q > hi_q) ? hi_q : selV_q); // R05
    offset = (selV_q == {BEAM_W{1'b0}}) ? 9'h000 : ({1'b0, vClamp - lo_q} + 9'h001);
    prod   = offset * step; // R07
    if (offset == 9'h000)
      codeNext = `BAMO_DAC_MIN; // R08
    else if (offset >= span)
      codeNext = `BAMO_DAC_FULL; // R09
    else
      codeNext = prod[11:0];
    if (inv_q)
      codeNext = `BAMO_DAC_FULL - codeNext; // R06
    if (off_q)
      codeNext = `BAMO_DAC_MIN; // R03
  end

  bamo_divider #(
    .NUM_W (13),
    .DEN_W (9)
  ) u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .start (divStart_q),
    .num   (`BAMO_DAC_SPAN),
    .den   (span),
    .busy  (divBusy),
    .done  (divDone),
    .quot  (step)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= ST_IDLE;
      prevState_q <= {NBEAMS{1'b0}};
      stableCnt_q <= 8'h00;
      selV_q      <= {BEAM_W{1'b0}};
      lo_q        <= {BEAM_W{1'b0}};
      hi_q        <= {BEAM_W{1'b0}};
      inv_q       <= 1'b0;
      off_q       <= 1'b1;
      type_q      <= `BAMO_TYPE_OFF;
      pins_q      <= 3'h0;
      divStart_q  <= 1'b0;
      dacCode     <= `BAMO_DAC_MIN;
      dacType     <= `BAMO_TYPE_OFF;
      dacPinEn    <= 3'h0;
      dacUpdate   <= 1'b0;
    end else begin
      divStart_q <= 1'b0;
      dacUpdate  <= 1'b0;
      if (measStrobe) begin
        prevState_q <= beamState;
        stableCnt_q <= cntNext; // R11
      end
      case (state_q)
        ST_IDLE: begin
          // Strobes landing during a division are skipped, not queued
          if (measStrobe && cfgReady &&
              ({1'b0, cntNext} >= cfg_q[`BAMO_IDX_FILT][`BAMO_F_DEPTH])) begin // R11
            selV_q <= selV;
            if (cfg_q[`BAMO_IDX_RANGE][`BAMO_F_END] < cfg_q[`BAMO_IDX_RANGE][`BAMO_F_START]) begin
              lo_q  <= cfg_q[`BAMO_IDX_RANGE][`BAMO_F_END];
              hi_q  <= cfg_q[`BAMO_IDX_RANGE][`BAMO_F_START];
              inv_q <= 1'b1; // R06
            end else begin
              lo_q  <= cfg_q[`BAMO_IDX_RANGE][`BAMO_F_START]; // R05
              hi_q  <= cfg_q[`BAMO_IDX_RANGE][`BAMO_F_END];
              inv_q <= 1'b0;
            end
            off_q      <= (cfg_q[`BAMO_IDX_CTRL][`BAMO_F_TYPE] == `BAMO_TYPE_OFF) ||
                          (cfg_q[`BAMO_IDX_CTRL][`BAMO_F_FUNC] == `BAMO_FN_OFF);
            type_q     <= cfg_q[`BAMO_IDX_CTRL][`BAMO_F_TYPE]; // R03
            pins_q     <= cfg_q[`BAMO_IDX_CTRL][`BAMO_F_PINS];
            divStart_q <= 1'b1;
            state_q    <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (divDone) begin
            dacCode   <= codeNext; // R15
            dacType   <= type_q;
            dacPinEn  <= off_q ? 3'h0 : pins_q; // R10
            dacUpdate <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // bamo_mapper

// ### rtl/bamo_map.vh
/*
  Register map, field layout, reset values and encodings of the beam-to-analog mapper.
  Assumes inclusion by bare name from the design and bench files of this block.
*/
`ifndef BAMO_MAP_VH
`define BAMO_MAP_VH

`define BAMO_AW          5
`define BAMO_OFF_CTRL    5'h00
`define BAMO_OFF_RANGE   5'h04
`define BAMO_OFF_FILT    5'h08
`define BAMO_OFF_STAT    5'h0c
`define BAMO_NCFG        3
`define BAMO_IDX_CTRL    2'h0
`define BAMO_IDX_RANGE   2'h1
`define BAMO_IDX_FILT    2'h2
`define BAMO_IDX_LAST    2'h2

`define BAMO_RST_CTRL    32'h0000_0000
`define BAMO_RST_RANGE   32'h0000_2001
`define BAMO_RST_FILT    32'h0000_0001
`define BAMO_WM_CTRL     32'h0000_0777
`define BAMO_WM_RANGE    32'h0000_ffff
`define BAMO_WM_FILT     32'h00ff_01ff

`define BAMO_F_TYPE      2:0
`define BAMO_F_FUNC      6:4
`define BAMO_F_PINS      10:8
`define BAMO_F_START     7:0
`define BAMO_F_END       15:8
`define BAMO_F_DEPTH     8:0
`define BAMO_F_SMOOTH    23:16
`define BAMO_DEPTH_MAX   9'h0ff
`define BAMO_DEPTH_MIN   9'h001

`define BAMO_TYPE_OFF    3'h0
`define BAMO_FN_OFF      3'h0
`define BAMO_FN_FST_BLK  3'h1
`define BAMO_FN_FST_CLR  3'h2
`define BAMO_FN_LST_BLK  3'h3
`define BAMO_FN_LST_CLR  3'h4
`define BAMO_FN_TOT_BLK  3'h5
`define BAMO_FN_TOT_CLR  3'h6

`define BAMO_DAC_SPAN    13'h1000
`define BAMO_DAC_FULL    12'hfff
`define BAMO_DAC_MIN     12'h000

`define BAMO_RESP_OKAY   2'b00
`define BAMO_RESP_SLVERR 2'b10

`define BAMO_ST_INV      16
`define BAMO_ST_LOADED   17
`define BAMO_ST_REJECT   18

`endif

// ### rtl/bamo_divider.v
/*
  Restoring sequential divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse given only while busy is low and den is non-zero.
*/
`timescale 1ns/1ps

module bamo_divider #(
  parameter NUM_W = 13,
  parameter DEN_W = 9
) (
  input  wire             clk,    // System clock
  input  wire             rst_b,  // Async reset, active low
  input  wire             start,  // Start pulse
  input  wire [NUM_W-1:0] num,    // Dividend
  input  wire [DEN_W-1:0] den,    // Divisor
  output reg              busy,   // Division running
  output reg              done,   // One-cycle pulse, quot valid
  output reg  [NUM_W-1:0] quot    // Quotient
);
  localparam CNT_W = $clog2(NUM_W + 1);

  reg [DEN_W-1:0] den_q;
  reg [DEN_W-1:0] rem_q;
  reg [CNT_W-1:0] cnt_q;
  reg [DEN_W:0]   trial;

  always @* begin
    trial = {rem_q, quot[NUM_W-1]};
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      quot  <= {NUM_W{1'b0}};
      den_q <= {DEN_W{1'b0}};
      rem_q <= {DEN_W{1'b0}};
      cnt_q <= {CNT_W{1'b0}};
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        quot  <= num;
        den_q <= den;
        rem_q <= {DEN_W{1'b0}};
        cnt_q <= NUM_W[CNT_W-1:0];
      end else if (busy) begin
        // Remainder stays below den, so it always fits DEN_W bits
        if (trial >= {1'b0, den_q}) begin
          rem_q <= trial[DEN_W-1:0] - den_q;
          quot  <= {quot[NUM_W-2:0], 1'b1};
        end else begin
          rem_q <= trial[DEN_W-1:0];
          quot  <= {quot[NUM_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // bamo_divider

// ### sim/bamo_nvstore.sv
/*
  Non-volatile word store model on the mapper's store port.
  Assumes one held request at a time; contents survive reset.
*/
`timescale 1ns/1ps
module bamo_nvstore (
  input  wire         clk,      // Clock
  input  wire         rst_b,    // Reset, active low
  input  wire         slowAck,  // Ack 4 cycles late
  input  wire         nvReq,    // Request level
  input  wire         nvWe,     // Request is a write
  input  wire  [1:0]  nvAddr,   // Word index
  input  wire  [31:0] nvWdata,  // Word to store
  output logic        nvAck,    // Ack pulse
  output logic [31:0] nvRdata   // Word, valid with ack
);
  logic [31:0] mem [3] = '{32'h711, 32'h2001, 32'h1};
  logic [2:0]  waitCnt;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nvAck   <= 1'b0;
      nvRdata <= 32'h5a5a_a5a5;
      waitCnt <= 3'h0;
    end else if (nvAck || !nvReq) begin
      nvAck   <= 1'b0;
      nvRdata <= ~nvRdata; // No stale word outside an answer
      waitCnt <= 3'h0;
    end else if (waitCnt == (slowAck ? 3'h4 : 3'h0)) begin
      nvAck   <= 1'b1;
      nvRdata <= mem[nvAddr];
      if (nvWe) mem[nvAddr] <= nvWdata;
    end else begin
      waitCnt <= waitCnt + 3'h1;
      nvRdata <= ~nvRdata;
    end
  end
endmodule // bamo_nvstore

// ### sim/bamo_assertions.sv
/*
  Port checker for the mapper.
  Assumes a bind to bamo_mapper; one clock, async low reset.
*/
`timescale 1ns/1ps
module bamo_assertions (
  input wire        clk,           // Clock
  input wire        rst_b,         // Reset, low
  input wire        s_axi_arvalid, // AR valid
  input wire        s_axi_arready, // AR ready
  input wire        s_axi_rvalid,  // R valid
  input wire [1:0]  s_axi_bresp,   // B response
  input wire        s_axi_bvalid,  // B valid
  input wire        s_axi_bready,  // B ready
  input wire        nvReq,         // Store request
  input wire        nvWe,          // Store write
  input wire [1:0]  nvAddr,        // Store index
  input wire        nvAck,         // Store ack
  input wire        measStrobe,    // Cycle strobe
  input wire [11:0] dacCode,       // Code
  input wire [2:0]  dacType,       // Range
  input wire [2:0]  dacPinEn,      // Pins
  input wire        dacUpdate,     // Reload
  input wire        cfgReady       // Restored
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_update_timing: assert property (dacUpdate |-> $past(measStrobe, 16))
    else $error("reload not 16 cycles after strobe");
  a_code_held: assert property ($changed(dacCode) |-> dacUpdate)
    else $error("code moved without reload");
  a_off_pins: assert property (dacUpdate && dacType == 3'h0 |-> dacPinEn == 3'h0)
    else $error("pins on with output off");
  a_update_ready: assert property (dacUpdate |-> cfgReady)
    else $error("reload before restore");
  a_restore_end: assert property ($rose(cfgReady) |->
      $past(nvAck) && !$past(nvWe) && $past(nvAddr) == 2'h2)
    else $error("restore end without last read");
  a_store_hold: assert property (nvReq && !nvAck |=>
      nvReq && $stable(nvAddr) && $stable(nvWe))
    else $error("store request moved before ack");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // bamo_assertions

// ### sim/bamo_mapper_tb_top.sv
/*
  Mapper bench: table rows, then hand-written cases.
  Assumes the map header and checker compiled alongside.
*/
`timescale 1ns/1ps
`include "bamo_map.vh"
module bamo_mapper_tb_top;
  typedef struct {logic [31:0] ctrl, range; logic [7:0] v; logic [11:0] code;} bamo_row_t;
  logic        clk = 1'b0, rst_b = 1'b0, awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0, panelWrEn = 1'b0, measStrobe = 1'b0;
  logic        slowAck = 1'b0;
  logic [4:0]  awAddr = 5'h00, arAddr = 5'h00;
  logic [1:0]  panelIdx = 2'h0;
  logic [31:0] wData = 32'h0, panelData = 32'h0, beamState = 32'h0;
  logic [7:0]  res [6] = '{default: 8'h03};
  wire         awReady, wReady, bValid, arReady, rValid, nvReq, nvWe, nvAck;
  wire         dacUpdate, cfgReady;
  wire  [1:0]  bResp, rResp, nvAddr;
  wire  [31:0] rData, nvWdata, nvRdata;
  wire  [11:0] dacCode;
  wire  [2:0]  dacType, dacPinEn;
  int          fails = 0, checked = 0, n, idx;
  bamo_row_t   rows [14] = '{
    '{32'h511, 32'h2001, 8'd0, 12'h0}, '{32'h511, 32'h2001, 8'd32, 12'hfff},
    '{32'h521, 32'h2001, 8'd16, 12'h800}, '{32'h531, 32'h2001, 8'd1, 12'h080},
    '{32'h541, 32'h2001, 8'd8, 12'h400}, '{32'h551, 32'h2001, 8'd24, 12'hc00},
    '{32'h561, 32'h2001, 8'd31, 12'hf80}, '{32'h701, 32'h2001, 8'd20, 12'h0},
    '{32'h710, 32'h2001, 8'd20, 12'h0}, '{32'h512, 32'h120, 8'd32, 12'h0},
    '{32'h512, 32'h120, 8'd1, 12'hf7f}, '{32'h512, 32'h120, 8'd0, 12'hfff},
    '{32'h314, 32'h705, 8'd6, 12'haaa}, '{32'h314, 32'h705, 8'd3, 12'h555}};

  always #25 clk = ~clk;

  bamo_nvstore store (.clk, .rst_b, .slowAck, .nvReq, .nvWe, .nvAddr, .nvWdata, .nvAck,
    .nvRdata);
  bamo_mapper DUT (
    .clk, .rst_b, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .panelWrEn, .panelIdx, .panelData, .nvReq, .nvWe, .nvAddr, .nvWdata, .nvAck, .nvRdata,
    .measStrobe, .beamState, .firstBlockedBeam(res[0]), .firstClearBeam(res[1]),
    .lastBlockedBeam(res[2]), .lastClearBeam(res[3]), .totalBlockedBeams(res[4]),
    .totalClearBeams(res[5]), .dacCode, .dacType, .dacPinEn, .dacUpdate, .cfgReady);

  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ck(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Bready lags so the slave must hold its response
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e = 2'b00);
    logic ta, tw, bv;
    int seen = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    repeat (100) begin
      @(negedge clk);
      ta = awReady === 1'b1;
      tw = wReady === 1'b1;
      bv = bValid === 1'b1 && bReady;
      if (bv) ck(bResp, e);
      if (bValid === 1'b1) seen++;
      @(posedge clk);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
      if (seen == 2) bReady <= 1'b1;
      if (bv) begin
        bReady <= 1'b0;
        return;
      end
    end
    fails++;
    wrap_up;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, m = 32'hffff_ffff,
    input logic [1:0] er = 2'b00);
    logic ta, rv;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    repeat (100) begin
      @(negedge clk);
      ta = arReady === 1'b1;
      rv = rValid === 1'b1;
      if (rv) ck(rData & m, e);
      if (rv) ck(rResp, er);
      @(posedge clk);
      if (ta) arValid <= 1'b0;
      if (rv) return;
    end
    fails++;
    wrap_up;
  endtask

  task automatic strobe(input logic want);
    logic got = 1'b0;
    measStrobe <= 1'b1;
    @(posedge clk) measStrobe <= 1'b0;
    repeat (20) @(negedge clk) if (dacUpdate === 1'b1) got = 1'b1;
    @(posedge clk);
    ck(got, want);
  endtask

  task automatic wait_cfg;
    for (n = 0; n < 300 && cfgReady !== 1'b1; n++) @(posedge clk);
    if (n == 300) begin
      fails++;
      wrap_up;
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    ck(dacCode, 32'h0);
    rst_b <= 1'b1;
    wait_cfg;
    rd(`BAMO_OFF_CTRL, 32'h711);
    rd(`BAMO_OFF_STAT, 32'h2_0000, 32'h2_0000);
    foreach (rows[i]) begin
      wr(`BAMO_OFF_CTRL, rows[i].ctrl);
      wr(`BAMO_OFF_RANGE, rows[i].range);
      idx = int'(rows[i].ctrl[6:4]) - 1;
      foreach (res[k]) res[k] <= (k == idx) ? rows[i].v : 8'h03;
      strobe(1'b1);
      ck(dacCode, rows[i].code);
      ck(dacType, rows[i].ctrl[2:0]);
      ck(dacPinEn, (rows[i].ctrl[2:0] == 3'h0 || idx < 0) ? 3'h0 : rows[i].ctrl[10:8]);
    end
    wr(`BAMO_OFF_FILT, 32'h100, 2'b10);
    rd(`BAMO_OFF_STAT, 32'h4_0000, 32'h4_0000);
    wr(`BAMO_OFF_FILT, 32'h0, 2'b10);
    rd(`BAMO_OFF_FILT, 32'h1);
    wr(`BAMO_OFF_FILT, 32'hff);
    rd(`BAMO_OFF_STAT, 32'h0, 32'h4_0000);
    wr(`BAMO_OFF_FILT, 32'ha_0003);
    beamState <= 32'h1;
    strobe(1'b0);
    strobe(1'b0);
    strobe(1'b1);
    wr(`BAMO_OFF_CTRL, 32'h511);
    wr(`BAMO_OFF_RANGE, 32'h2001);
    res[0] <= 8'd16;
    strobe(1'b1);
    ck(dacCode, 32'h0);
    res[4] <= 8'd12;
    strobe(1'b1);
    ck(dacCode, 32'h800);
    panelData <= 32'h222;
    panelWrEn <= 1'b1;
    @(posedge clk) panelWrEn <= 1'b0;
    rd(`BAMO_OFF_CTRL, 32'h222);
    wr(`BAMO_OFF_CTRL, 32'h333);
    rd(`BAMO_OFF_CTRL, 32'h333);
    wr(5'h10, 32'h1, 2'b10);
    rd(5'h14, 32'h0, 32'hffff_ffff, 2'b10);
    for (n = 0; n < 100 && store.mem[0] !== 32'h333; n++) @(posedge clk);
    ck(store.mem[0], 32'h333);
    slowAck <= 1'b1;
    rst_b <= 1'b0;
    @(posedge clk);
    ck(cfgReady, 32'h0);
    rst_b <= 1'b1;
    wait_cfg;
    rd(`BAMO_OFF_CTRL, 32'h333);
    wrap_up;
  end
endmodule // bamo_mapper_tb_top

bind bamo_mapper bamo_assertions chk (.clk, .rst_b, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .nvReq, .nvWe, .nvAddr,
  .nvAck, .measStrobe, .dacCode, .dacType, .dacPinEn, .dacUpdate, .cfgReady);
